// ### rtl/dcs_serializer_tx.sv
// How it works
// - Input characters are captured on host clock when select is 0, reference clock when 1.
// - Host-clock capture goes through the phase-align buffer; reference capture bypasses it.
// - Initialized buffer absorbs host clock phase drift of up to half its depth (two characters at depth 4).
// - Buffer slip raises the error output, held in host capture until the buffer is initialized again.
// - Writing 0 to the phase-align reset bit initializes the buffer.
// - In host capture, error low means no buffer slip since reset or the last init; characters captured correctly.
// - Outside self-test, while error is active the fixed error character is sent instead of data.
// - Self-test turns a register into an LFSR with a 511-character sequence.
// - Device reset sets both self-test latches to disabled.
// - During self-test the parallel data inputs are ignored.
// - Bit rate is ten or twenty times the reference, chosen by rate select.
// - A character-rate clock is derived and driven out per channel.
// - Characters are shifted out least significant bit first to the drivers.
// - Each serial driver has its own enable; disabled drivers are off.
// - With both drivers off the channel's transmit logic is idle.
// - Device reset disables all serial drivers.
// - Rate 0 gives x10 and reference-rate clock out; rate 1 x20 and double.
// - Reference capture at x20 uses both reference clock edges.
// - A write loads the addressed latch bank: two bits for static, four bits for spare and dynamic.
// - Reset sets the capture clock select to 1.
`timescale 1ns/10ps
module dcs_serializer_tx import dcs_pkg::*; #(
	parameter int NCH = 2,
	parameter int PAB_DEPTH = 4,
	parameter int PER_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [5:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NCH-1:0][CHAR_W-1:0] parallel_char_in,
	input wire logic [NCH-1:0] host_tx_clock,
	input wire logic [NCH-1:0] channel_ref_clock,
	input wire logic [NCH-1:0][1:0] speed_range_select,
	output logic [NCH-1:0] phase_align_error,
	output logic [NCH-1:0] char_clock_out,
	output logic [NCH-1:0] serial_out_primary,
	output logic [NCH-1:0] serial_out_secondary,
	output logic [NCH-1:0] primary_driver_on,
	output logic [NCH-1:0] secondary_driver_on
);
	generate
		if (NCH < 1 || NCH > 2) begin : g_bad_nch
			$error("dcs_serializer_tx serves one or two channels");
		end
		if (PER_W < 6) begin : g_bad_per
			$error("dcs_serializer_tx period counter too narrow");
		end
	endgenerate

	// Configuration latches, one bit per channel except the 4-bit spare bank
	logic [NCH-1:0] capture_clock_select;
	logic [NCH-1:0] multiplier_rate_select;
	logic [NCH-1:0] self_test_disable_bit;
	logic [NCH-1:0] primary_driver_enable;
	logic [NCH-1:0] secondary_driver_enable;
	logic [NCH-1:0] phase_align_reset_bit;
	logic [NCH-1:0][3:0] spare_bank_reg;
	logic [NCH-1:0] err_live;
	logic [NCH-1:0] chan_on;

	// APB transfer decode
	logic [3:0] reg_idx;
	logic access;
	logic wr_stb;
	logic [31:0] rd_mux;
	logic rd_hit;

	assign reg_idx = paddr[5:2];
	assign access = psel && penable && !pready;
	assign wr_stb = psel && penable && pready && pwrite;

	// Read multiplexer; the status word shows each channel's state
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = (reg_idx == STATUS_IDX);
		for (int c = 0; c < NCH; c++) begin
			if (reg_idx == BANK_A_STATIC + 4'(c) * BANK_STRIDE) begin
				rd_hit = 1'b1;
				rd_mux[F_CKSEL] = capture_clock_select[c];
				rd_mux[F_RATE] = multiplier_rate_select[c];
			end
			if (reg_idx == BANK_A_SPARE + 4'(c) * BANK_STRIDE) begin
				rd_hit = 1'b1;
				rd_mux[BANK_W-1:0] = spare_bank_reg[c];
			end
			if (reg_idx == BANK_A_DYN + 4'(c) * BANK_STRIDE) begin
				rd_hit = 1'b1;
				rd_mux[F_BIST_DIS] = self_test_disable_bit[c];
				rd_mux[F_OE1] = primary_driver_enable[c];
				rd_mux[F_OE2] = secondary_driver_enable[c];
				rd_mux[F_PAB_RST] = phase_align_reset_bit[c];
			end
			if (reg_idx == STATUS_IDX) begin
				rd_mux[c*S_STRIDE+S_ERR] = err_live[c];
				rd_mux[c*S_STRIDE+S_BIST] = !self_test_disable_bit[c];
				rd_mux[c*S_STRIDE+S_ON] = chan_on[c];
				rd_mux[c*S_STRIDE+S_RSVD] = multiplier_rate_select[c]
					&& speed_range_select[c] == SPD_LOW;
			end
		end
	end

	// One wait state: data, error and pready are registered together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			if (access) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= !rd_hit || (pwrite && reg_idx == STATUS_IDX);
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			localparam logic [3:0] IDX_STATIC = BANK_A_STATIC + 4'(ch) * BANK_STRIDE;
			localparam logic [3:0] IDX_SPARE = BANK_A_SPARE + 4'(ch) * BANK_STRIDE;
			localparam logic [3:0] IDX_DYN = BANK_A_DYN + 4'(ch) * BANK_STRIDE;

			dcs_pab_if pab ();

			logic ref_d_reg;
			logic host_d_reg;
			logic ref_rise;
			logic ref_fall;
			logic host_rise;
			logic char_stb;
			logic use_pab;
			logic bist_on;
			logic pab_init_reg;
			logic push_reg;
			logic [CHAR_W-1:0] input_reg;
			logic [CHAR_W-1:0] lfsr_char;
			logic [CHAR_W-1:0] next_char;
			logic [PER_W-1:0] per_cnt_reg;
			logic [PER_W-1:0] period_reg;
			logic [PER_W-1:0] acc_reg;
			logic [PER_W-1:0] acc_sum;
			logic bit_stb;
			logic [CHAR_W-1:0] shift_reg;
			logic [3:0] bit_idx_reg;
			logic ckout_reg;

			// Latch banks, each write loads all its bits at once (two static, four spare and dynamic)
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					capture_clock_select[ch] <= RST_CKSEL;
					multiplier_rate_select[ch] <= RST_RATE;
					spare_bank_reg[ch] <= RST_SPARE;
					self_test_disable_bit[ch] <= RST_BIST_DIS;
					primary_driver_enable[ch] <= RST_OE;
					secondary_driver_enable[ch] <= RST_OE;
					phase_align_reset_bit[ch] <= RST_PAB_RST;
				end else if (wr_stb) begin
					if (reg_idx == IDX_STATIC) begin
						capture_clock_select[ch] <= pwdata[F_CKSEL];
						multiplier_rate_select[ch] <= pwdata[F_RATE];
					end
					if (reg_idx == IDX_SPARE) begin
						spare_bank_reg[ch] <= pwdata[BANK_W-1:0];
					end
					if (reg_idx == IDX_DYN) begin
						self_test_disable_bit[ch] <= pwdata[F_BIST_DIS];
						primary_driver_enable[ch] <= pwdata[F_OE1];
						secondary_driver_enable[ch] <= pwdata[F_OE2];
						phase_align_reset_bit[ch] <= pwdata[F_PAB_RST];
					end
				end
			end

			// Buffer init pulse on a write of 0 to the reset bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pab_init_reg <= 1'b0;
				end else begin
					pab_init_reg <= wr_stb && reg_idx == IDX_DYN && !pwdata[F_PAB_RST];
				end
			end

			// Edge detection of the sampled clock pins
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ref_d_reg <= 1'b0;
					host_d_reg <= 1'b0;
				end else begin
					ref_d_reg <= channel_ref_clock[ch];
					host_d_reg <= host_tx_clock[ch];
				end
			end

			assign ref_rise = channel_ref_clock[ch] && !ref_d_reg;
			assign ref_fall = !channel_ref_clock[ch] && ref_d_reg;
			assign host_rise = host_tx_clock[ch] && !host_d_reg;
			assign chan_on[ch] = primary_driver_enable[ch] || secondary_driver_enable[ch];
			assign bist_on = !self_test_disable_bit[ch];
			assign use_pab = !capture_clock_select[ch];
			// Character clock: every rising edge at x10, both edges at x20
			assign char_stb = chan_on[ch]
				&& (ref_rise || (multiplier_rate_select[ch] && ref_fall));

			// Input register, frozen while self-test runs
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					input_reg <= '0;
				end else if (chan_on[ch] && !bist_on) begin
					if (capture_clock_select[ch] ? char_stb : host_rise) begin
						input_reg <= parallel_char_in[ch];
					end
				end
			end

			// Host-side captures enter the buffer one cycle later
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					push_reg <= 1'b0;
				end else begin
					push_reg <= chan_on[ch] && !bist_on && use_pab && host_rise;
				end
			end

			assign pab.init = pab_init_reg;
			assign pab.push = push_reg;
			assign pab.wdata = input_reg;
			assign pab.pop = char_stb && use_pab && !bist_on;
			assign err_live[ch] = pab.err && use_pab;

			dcs_pab #(.DEPTH(PAB_DEPTH)) u_pab (
				.pclk(pclk),
				.presetn(presetn),
				.pab(pab)
			);

			dcs_lfsr u_lfsr (
				.pclk(pclk),
				.presetn(presetn),
				.enable(bist_on && chan_on[ch]),
				.advance(char_stb),
				.char_out(lfsr_char)
			);

			// Source of the next character to send
			always_comb begin
				if (bist_on) begin
					next_char = lfsr_char;
				end else if (use_pab) begin
					next_char = pab.err ? ERR_CHAR : pab.rdata;
				end else begin
					next_char = input_reg;
				end
			end

			// Character period in clock cycles, measured between strobes
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					per_cnt_reg <= '0;
					period_reg <= '1;
				end else if (!chan_on[ch]) begin
					per_cnt_reg <= '0;
				end else if (char_stb) begin
					per_cnt_reg <= '0;
					period_reg <= per_cnt_reg + 1'b1;
				end else if (per_cnt_reg != '1) begin
					per_cnt_reg <= per_cnt_reg + 1'b1;
				end
			end

			// Fractional divider: nine bit strobes after each character strobe, ten bit slots per measured period
			assign acc_sum = acc_reg + PER_W'(BITS_PER_CHAR);
			assign bit_stb = chan_on[ch] && !char_stb && acc_sum >= period_reg;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					acc_reg <= '0;
				end else if (char_stb || !chan_on[ch]) begin
					acc_reg <= '0;
				end else if (bit_stb) begin
					acc_reg <= acc_sum - period_reg;
				end else begin
					acc_reg <= acc_sum;
				end
			end

			// Transmit shifter, bit 0 leaves first
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					shift_reg <= '0;
					bit_idx_reg <= '0;
				end else if (!chan_on[ch]) begin
					shift_reg <= '0;
					bit_idx_reg <= '0;
				end else if (char_stb) begin
					shift_reg <= next_char;
					bit_idx_reg <= '0;
				end else if (bit_stb && bit_idx_reg != LAST_BIT) begin
					shift_reg <= {1'b0, shift_reg[CHAR_W-1:1]};
					bit_idx_reg <= bit_idx_reg + 1'b1;
				end
			end

			// Character clock out: follows reference at x10, double rate at x20
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ckout_reg <= 1'b0;
				end else if (!chan_on[ch]) begin
					ckout_reg <= 1'b0;
				end else if (!multiplier_rate_select[ch]) begin
					ckout_reg <= channel_ref_clock[ch];
				end else if (char_stb) begin
					ckout_reg <= 1'b1;
				end else if (bit_stb && bit_idx_reg == HALF_CHAR_BIT) begin
					ckout_reg <= 1'b0;
				end
			end

			// Registered pins; a disabled driver sits at 0
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					serial_out_primary[ch] <= 1'b0;
					serial_out_secondary[ch] <= 1'b0;
					primary_driver_on[ch] <= 1'b0;
					secondary_driver_on[ch] <= 1'b0;
					phase_align_error[ch] <= 1'b0;
					char_clock_out[ch] <= 1'b0;
				end else begin
					serial_out_primary[ch] <= primary_driver_enable[ch] && shift_reg[0];
					serial_out_secondary[ch] <= secondary_driver_enable[ch] && shift_reg[0];
					primary_driver_on[ch] <= primary_driver_enable[ch];
					secondary_driver_on[ch] <= secondary_driver_enable[ch];
					phase_align_error[ch] <= err_live[ch];
					char_clock_out[ch] <= ckout_reg;
				end
			end
		end
	endgenerate
endmodule : dcs_serializer_tx

// ### rtl/dcs_pkg.sv
package dcs_pkg;
	// Character and lane geometry
	localparam int CHAR_W = 10;
	localparam int BITS_PER_CHAR = 10;
	localparam int BANK_W = 4;
	// Latch bank indices; byte address is four times the index
	localparam logic [3:0] BANK_A_STATIC = 4'h0;
	localparam logic [3:0] BANK_A_SPARE = 4'h1;
	localparam logic [3:0] BANK_A_DYN = 4'h2;
	localparam logic [3:0] BANK_B_STATIC = 4'h5;
	localparam logic [3:0] BANK_B_SPARE = 4'h6;
	localparam logic [3:0] BANK_B_DYN = 4'h7;
	localparam logic [3:0] STATUS_IDX = 4'h8;
	localparam logic [3:0] BANK_STRIDE = 4'h5;
	// Static bank fields
	localparam int F_CKSEL = 0;
	localparam int F_RATE = 1;
	// Dynamic bank fields
	localparam int F_BIST_DIS = 0;
	localparam int F_OE1 = 1;
	localparam int F_OE2 = 2;
	localparam int F_PAB_RST = 3;
	// Status fields, four bits per channel
	localparam int S_ERR = 0;
	localparam int S_BIST = 1;
	localparam int S_ON = 2;
	localparam int S_RSVD = 3;
	localparam int S_STRIDE = 4;
	// Reset values
	localparam logic RST_CKSEL = 1'b1;
	localparam logic RST_RATE = 1'b0;
	localparam logic RST_BIST_DIS = 1'b1;
	localparam logic RST_OE = 1'b0;
	localparam logic RST_PAB_RST = 1'b1;
	localparam logic [3:0] RST_SPARE = 4'h0;
	// Fixed error character, bit 0 leaves first
	localparam logic [CHAR_W-1:0] ERR_CHAR = 10'h079;
	// Self-test generator seed
	localparam logic [8:0] LFSR_SEED = 9'h1FF;
	// Three-level speed range encoding
	localparam logic [1:0] SPD_LOW = 2'h0;
	localparam logic [1:0] SPD_MID = 2'h1;
	localparam logic [1:0] SPD_HIGH = 2'h2;
	// Bit position of the half-character point of the character clock
	localparam logic [3:0] HALF_CHAR_BIT = 4'h4;
	localparam logic [3:0] LAST_BIT = 4'h9;
endpackage : dcs_pkg

// ### rtl/dcs_pab_if.sv
`timescale 1ns/10ps
interface dcs_pab_if;
	import dcs_pkg::*;
	logic init;
	logic push;
	logic [CHAR_W-1:0] wdata;
	logic pop;
	logic [CHAR_W-1:0] rdata;
	logic err;
	modport buffer (input init, input push, input wdata, input pop, output rdata, output err);
	modport user (output init, output push, output wdata, output pop, input rdata, input err);
endinterface : dcs_pab_if

// ### rtl/dcs_pab.sv
`timescale 1ns/10ps
module dcs_pab import dcs_pkg::*; #(
	parameter int DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	dcs_pab_if.buffer pab
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("dcs_pab depth must be a power of two of at least 2");
		end
	endgenerate

	logic [CHAR_W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic err_reg;
	logic overflow;
	logic underflow;

	// Slip past capacity in either direction
	assign overflow = pab.push && !pab.pop && count_reg == FULL;
	assign underflow = pab.pop && !pab.push && count_reg == '0;
	assign pab.rdata = mem[rd_ptr_reg];
	assign pab.err = err_reg;

	// Storage
	always_ff @(posedge pclk) begin
		if (pab.push && !overflow) begin
			mem[wr_ptr_reg] <= pab.wdata;
		end
	end

	// Pointers; init centres the fill level at half the depth, DEPTH/2 characters either way
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (pab.init) begin
			wr_ptr_reg <= HALF[AW-1:0];
			rd_ptr_reg <= '0;
			count_reg <= HALF;
		end else begin
			if (pab.push && !overflow) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pab.pop && !underflow) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(pab.push && !overflow)
				- (AW+1)'(pab.pop && !underflow);
		end
	end

	// Sticky loss flag, a slip in the init cycle still sets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg <= 1'b0;
		end else if (overflow || underflow) begin
			err_reg <= 1'b1;
		end else if (pab.init) begin
			err_reg <= 1'b0;
		end
	end
endmodule : dcs_pab

// ### rtl/dcs_lfsr.sv
`timescale 1ns/10ps
module dcs_lfsr import dcs_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic advance,
	output logic [CHAR_W-1:0] char_out
);
	logic [8:0] state_reg;

	// Nine-stage maximal sequence, 511 states, then parity on top
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= LFSR_SEED;
		end else if (!enable) begin
			state_reg <= LFSR_SEED;
		end else if (advance) begin
			state_reg <= {state_reg[7:0], state_reg[8] ^ state_reg[4]};
		end
	end

	assign char_out = {^state_reg, state_reg};
endmodule : dcs_lfsr

// ### test/dcs_serializer_tx_chk.sv
`timescale 1ns/10ps
module dcs_serializer_tx_chk import dcs_pkg::*; #(
	parameter int NCH = 2,
	parameter int PAB_DEPTH = 4,
	parameter int PER_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [5:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NCH-1:0][CHAR_W-1:0] parallel_char_in,
	input wire logic [NCH-1:0] host_tx_clock,
	input wire logic [NCH-1:0] channel_ref_clock,
	input wire logic [NCH-1:0][1:0] speed_range_select,
	input wire logic [NCH-1:0] phase_align_error,
	input wire logic [NCH-1:0] char_clock_out,
	input wire logic [NCH-1:0] serial_out_primary,
	input wire logic [NCH-1:0] serial_out_secondary,
	input wire logic [NCH-1:0] primary_driver_on,
	input wire logic [NCH-1:0] secondary_driver_on
);
	logic init_wr;
	logic bad_idx;
	logic [3:0] since_init;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Buffer init write on channel A, and refused indices
	assign init_wr = pready && pwrite && paddr[5:2] == BANK_A_DYN && !pwdata[F_PAB_RST];
	assign bad_idx = paddr[5:2] inside {4'h3, 4'h4} || paddr[5:2] > STATUS_IDX;
	// Cycles since last init, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_init <= 4'hF;
		end else if (init_wr) begin
			since_init <= 4'h0;
		end else if (since_init != 4'hF) begin
			since_init <= since_init + 4'h1;
		end
	end
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	property p_one_wait; psel && penable && !pready |=> pready; endproperty
	a_one_wait: assert property (p_one_wait) else $error("ready not one cycle after access");
	property p_ready_cause; pready |-> psel && penable && $past(penable); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready outside access");
	property p_refused; pready && (bad_idx || (pwrite && paddr[5:2] == STATUS_IDX)) |-> pslverr;
	endproperty
	a_refused: assert property (p_refused) else $error("bad access not refused");
	property p_accepted; pready && !bad_idx && paddr[5:2] != STATUS_IDX |-> !pslverr; endproperty
	a_accepted: assert property (p_accepted) else $error("good access refused");
	property p_err_pair; pslverr |-> pready && $past(psel); endproperty
	a_err_pair: assert property (p_err_pair) else $error("error without ready");
	property p_rd_upper;
		pready && !pwrite |-> prdata[31:8] == 24'h0
			&& (paddr[5:2] == STATUS_IDX || prdata[7:4] == 4'h0);
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	property p_pri_quiet; !primary_driver_on[0] ##1 !primary_driver_on[0] |-> !serial_out_primary[0];
	endproperty
	a_pri_quiet: assert property (p_pri_quiet) else $error("disabled primary toggles");
	property p_sec_quiet;
		!secondary_driver_on[1] ##1 !secondary_driver_on[1] |-> !serial_out_secondary[1];
	endproperty
	a_sec_quiet: assert property (p_sec_quiet) else $error("disabled secondary toggles");
	property p_reset_off; $rose(presetn) |-> primary_driver_on == '0 && secondary_driver_on == '0;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("driver on after reset");
	property p_err_sticky; phase_align_error[0] && since_init == 4'hF |=> phase_align_error[0];
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error dropped without init");
	c_init: cover property (init_wr);
	c_err: cover property ($rose(phase_align_error[0]));
	c_refused: cover property (pslverr);
	c_both_on: cover property (primary_driver_on[0] && secondary_driver_on[0]);
endmodule : dcs_serializer_tx_chk
bind dcs_serializer_tx dcs_serializer_tx_chk #(.NCH(NCH), .PAB_DEPTH(PAB_DEPTH), .PER_W(PER_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.parallel_char_in(parallel_char_in), .host_tx_clock(host_tx_clock),
	.channel_ref_clock(channel_ref_clock), .speed_range_select(speed_range_select),
	.phase_align_error(phase_align_error), .char_clock_out(char_clock_out),
	.serial_out_primary(serial_out_primary), .serial_out_secondary(serial_out_secondary),
	.primary_driver_on(primary_driver_on), .secondary_driver_on(secondary_driver_on)
);

// ### test/dcs_rx_model.sv
`timescale 1ns/10ps
module dcs_rx_model (
	input wire logic pclk,
	input wire logic serial_in,
	output logic [59:0] hist
);
	// Oversampled line history, newest in bit 0; bench rebuilds chars LSB first
	always @(posedge pclk) begin
		hist <= {hist[58:0], serial_in};
	end
endmodule : dcs_rx_model

// ### test/dual_channel_serializer_tx_bench.sv
`timescale 1ns/10ps
module dual_channel_serializer_tx_bench;
	import dcs_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [5:0] paddr = 6'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0][CHAR_W-1:0] char_in = '0;
	logic host_clk = 1'h0;
	logic [1:0] ref_clk = 2'h0;
	logic [1:0][1:0] spd = {SPD_MID, SPD_MID};
	logic [1:0] err;
	logic [1:0] cko;
	logic [1:0] s_pri;
	logic [1:0] s_sec;
	logic [1:0] pri_on;
	logic [1:0] sec_on;
	logic [59:0] hist_a;
	logic [59:0] hist_b;
	logic [31:0] rd;
	logic rerr;
	int ref_per[2] = '{20, 40};
	int ref_cnt[2] = '{0, 0};
	int host_per = 20;
	int host_cnt = 3;
	int miscompares = 0;
	int checked = 0;

	always #5 pclk = ~pclk;
	// Reference and host clocks from pclk counters
	always @(posedge pclk) begin
		for (int c = 0; c < 2; c++) begin
			ref_cnt[c] <= (ref_cnt[c] + 1) % ref_per[c];
			ref_clk[c] <= ref_cnt[c] < ref_per[c] / 2;
		end
		host_cnt <= (host_cnt + 1) % host_per;
		host_clk <= host_cnt < host_per / 2;
	end
	dcs_serializer_tx uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.parallel_char_in(char_in), .host_tx_clock({host_clk, host_clk}),
		.channel_ref_clock(ref_clk), .speed_range_select(spd), .phase_align_error(err),
		.char_clock_out(cko), .serial_out_primary(s_pri), .serial_out_secondary(s_sec),
		.primary_driver_on(pri_on), .secondary_driver_on(sec_on)
	);
	dcs_rx_model rx_a (.pclk(pclk), .serial_in(s_pri[0]), .hist(hist_a));
	dcs_rx_model rx_b (.pclk(pclk), .serial_in(s_pri[1]), .hist(hist_b));

	task automatic end_sim;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	// Line history must be a constant char, LSB first, rep samples per bit
	task automatic chk_stream(input logic [59:0] h, input logic [9:0] ch, input int rep);
		bit ok;
		bit hit;
		hit = 0;
		for (int k = 0; k < 10 * rep; k++) begin
			ok = 1;
			for (int j = 0; j < 60; j++) begin
				if (h[j] !== ch[((k + 60 * rep - j) % (10 * rep)) / rep]) ok = 0;
			end
			if (ok) hit = 1;
		end
		chk({31'h0, hit}, 32'h1, $sformatf("stream of %h", ch));
	endtask : chk_stream
	task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 50) chk(32'h0, 32'h1, "ready timeout");
		@(posedge pclk);
	endtask : apb
	task automatic cko_edges(input int exp);
		int e;
		int e_b;
		int d;
		logic prev;
		logic prev_b;
		e = 0;
		e_b = 0;
		d = 0;
		prev = cko[0];
		prev_b = cko[1];
		repeat (200) begin
			@(posedge pclk);
			if (cko[0] && !prev) e++;
			if (cko[1] && !prev_b) e_b++;
			if (s_sec !== s_pri) d++;
			prev = cko[0];
			prev_b = cko[1];
		end
		chk(e, exp, "char clock edges");
		chk(e_b, 200 / ref_per[1], "char clock edges B");
		chk(d, 0, "secondary lane data");
	endtask : cko_edges
	task automatic t_reset;
		logic [31:0] exp[10] = '{32'h1, 32'h0, 32'h9, 32'h0, 32'h0, 32'h1, 32'h0, 32'h9, 32'h0, 32'h0};
		logic eb[10] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
		for (int i = 0; i < 10; i++) begin
			apb(1'h0, i[3:0], 32'h0);
			if (!eb[i]) chk(rd, exp[i], "reset value");
			chk({31'h0, rerr}, {31'h0, eb[i]}, "read refusal");
		end
		apb(1'h1, STATUS_IDX, 32'hF);
		chk({31'h0, rerr}, 32'h1, "status write");
		apb(1'h1, BANK_B_SPARE, 32'hA);
		apb(1'h0, BANK_B_SPARE, 32'h0);
		chk(rd, 32'hA, "spare bank");
		chk({28'h0, pri_on, sec_on}, 32'h0, "drivers at reset");
	endtask : t_reset
	task automatic t_drivers;
		apb(1'h1, BANK_A_DYN, 32'hB);
		apb(1'h1, BANK_B_DYN, 32'hD);
		repeat (40) @(posedge pclk);
		chk({28'h0, pri_on, sec_on}, 32'h6, "driver enables");
		repeat (40) begin
			@(posedge pclk);
			chk({30'h0, s_sec[0], s_pri[1]}, 32'h0, "off lanes low");
		end
		apb(1'h1, BANK_B_DYN, 32'h9);
		repeat (20) @(posedge pclk);
		apb(1'h0, STATUS_IDX, 32'h0);
		chk(rd, 32'h4, "channel on flags");
		apb(1'h1, BANK_A_DYN, 32'hF);
		apb(1'h1, BANK_B_DYN, 32'hF);
	endtask : t_drivers
	task automatic t_refcap;
		char_in <= {10'h0F1, 10'h2D3};
		repeat (600) @(posedge pclk);
		chk_stream(hist_a, 10'h2D3, 2);
		chk_stream(hist_b, 10'h0F1, 4);
		cko_edges(10);
		apb(1'h1, BANK_A_STATIC, 32'h3);
		repeat (600) @(posedge pclk);
		chk_stream(hist_a, 10'h2D3, 1);
		chk_stream(hist_b, 10'h0F1, 4);
		cko_edges(20);
		spd[0] <= SPD_LOW;
		apb(1'h0, STATUS_IDX, 32'h0);
		chk(rd, 32'h4C, "reserved combo flag");
		spd[0] <= SPD_MID;
		apb(1'h1, BANK_A_STATIC, 32'h1);
		repeat (600) @(posedge pclk);
	endtask : t_refcap
	task automatic t_selftest;
		logic [59:0] h0;
		apb(1'h1, BANK_A_DYN, 32'hE);
		repeat (600) @(posedge pclk);
		apb(1'h0, STATUS_IDX, 32'h0);
		chk({31'h0, rd[S_BIST]}, 32'h1, "self-test flag");
		h0 = hist_a;
		repeat (20) @(posedge pclk);
		chk({31'h0, hist_a !== h0}, 32'h1, "pattern not input");
		h0 = hist_a;
		char_in[0] <= 10'h3FF;
		repeat (5110) @(posedge pclk);
		char_in[0] <= 10'h2D3;
		repeat (5110) @(posedge pclk);
		chk({31'h0, hist_a === h0}, 32'h1, "pattern period");
		apb(1'h1, BANK_A_DYN, 32'hF);
		repeat (600) @(posedge pclk);
		chk_stream(hist_a, 10'h2D3, 2);
	endtask : t_selftest
	task automatic t_buffer;
		apb(1'h1, BANK_A_STATIC, 32'h0);
		apb(1'h1, BANK_A_DYN, 32'h7);
		apb(1'h1, BANK_A_DYN, 32'hF);
		host_per <= 22;
		repeat (22) @(posedge pclk);
		host_per <= 20;
		repeat (600) @(posedge pclk);
		chk({30'h0, err}, 32'h0, "no slip");
		chk_stream(hist_a, 10'h2D3, 2);
		host_per <= 16;
		repeat (400) @(posedge pclk);
		host_per <= 20;
		repeat (300) @(posedge pclk);
		chk({30'h0, err}, 32'h1, "slip held");
		chk_stream(hist_a, ERR_CHAR, 2);
		apb(1'h1, BANK_A_DYN, 32'h7);
		apb(1'h1, BANK_A_DYN, 32'hF);
		repeat (600) @(posedge pclk);
		chk({31'h0, err[0]}, 32'h0, "slip cleared");
		chk_stream(hist_a, 10'h2D3, 2);
	endtask : t_buffer
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		t_drivers;
		t_refcap;
		t_selftest;
		t_buffer;
		end_sim;
	end
	// Watchdog well above the expected run length
	initial begin
		repeat (40000) @(posedge pclk);
		chk(32'h0, 32'h1, "watchdog");
		end_sim;
	end
endmodule : dual_channel_serializer_tx_bench
